/* File: include/cpu_regs_pkg.sv */
package cpu_regs_pkg;
	localparam int XLEN = 32;
	localparam int PC_BITS = 26;
	localparam logic [31:0] PC_MASK = 32'h03ff_fffe;
	localparam logic [31:0] PCSAVE_MASK = 32'h03ff_ffff;
	localparam logic [31:0] STAT_MASK = 32'h0000_08ff;
	localparam logic [31:0] TBASE_MASK = 32'h03ff_fffe;
	localparam logic [31:0] DIR_WR_MASK = 32'h0000_7f76;
	localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam int ID_BIT = 5;
	localparam int EP_BIT = 6;
	localparam int NP_BIT = 7;
	localparam int DM_BIT = 0;
	localparam int CS_BIT = 12;
	localparam logic [4:0] SR_IRQ_PC = 5'h00;
	localparam logic [4:0] SR_IRQ_ST = 5'h01;
	localparam logic [4:0] SR_NMI_PC = 5'h02;
	localparam logic [4:0] SR_NMI_ST = 5'h03;
	localparam logic [4:0] SR_CAUSE = 5'h04;
	localparam logic [4:0] SR_STATUS = 5'h05;
	localparam logic [4:0] SR_TC_PC = 5'h10;
	localparam logic [4:0] SR_TC_ST = 5'h11;
	localparam logic [4:0] SR_TRAP_PC = 5'h12;
	localparam logic [4:0] SR_TRAP_ST = 5'h13;
	localparam logic [4:0] SR_TC_BASE = 5'h14;
	localparam logic [4:0] SR_DBG_IF = 5'h15;
	localparam logic [4:0] SR_BRK_CTL = 5'h16;
	localparam logic [4:0] SR_PROG_ID = 5'h17;
	localparam logic [4:0] SR_BRK_FIRST = 5'h18;
	localparam logic [4:0] SR_BRK_LAST = 5'h1b;
	localparam logic [1:0] RET_IRQ = 2'h0;
	localparam logic [1:0] RET_NMI = 2'h1;
	localparam logic [1:0] RET_TC = 2'h2;

	typedef struct packed {
		logic        en;
		logic [4:0]  num;
		logic [31:0] data;
	} sysreg_req_s;

	typedef struct packed {
		logic        irq;
		logic        nmi;
		logic        tcall;
		logic        dbg_enter;
		logic        dbg_exit;
		logic [31:0] cause;
		logic [31:0] ret_pc;
	} event_s;

	typedef struct packed {
		logic [31:0][31:0] gpr;
		logic [31:0]       pc;
		logic [31:0]       irq_saved_pc;
		logic [31:0]       irq_saved_status;
		logic [31:0]       nmi_saved_pc;
		logic [31:0]       nmi_saved_status;
		logic [31:0]       exception_cause;
		logic [31:0]       status_word;
		logic [31:0]       table_call_saved_pc;
		logic [31:0]       table_call_saved_status;
		logic [31:0]       trap_saved_pc;
		logic [31:0]       trap_saved_status;
		logic [31:0]       table_call_base;
		logic [31:0]       debug_interface;
		logic [31:0]       program_id;
		logic [4:0][1:0][31:0] brk;
		logic [31:0]       rd_a;
		logic [31:0]       rd_b;
		logic [31:0]       st_data;
		logic              st_valid;
	} state_s;
endpackage

/* File: src/cpu_register_set.sv */
`timescale 1ns/10ps
// Summary of operation
// RL1 - all program and system registers are 32 bits wide
// RL2 - thirty-two general registers, 0 to 31, for data or addresses
// RL3 - general register 0 always reads zero, writes ignored
// RL4 - program counter keeps 26 bits, bits 31 to 26 read zero
// RL5 - carry out of program counter bit 25 is dropped
// RL6 - program counter bit 0 is always zero
// RL7 - system registers reached only by number in load or store instruction
// RL8 - numbers 0-5 are save pairs, cause and status; 16-27 table/debug
// RL9 - cause register readable, loads to it have no effect
// RL10 - software avoids numbers 6 to 15 and 28 to 31
// RL11 - debug-restricted reads/writes only allowed in debug mode
// RL12 - numbers 22 and 24-27 pick one of two channels by select bit
// RL13 - interrupt return ignores bit 0 of the saved program counter
// RL14 - software writes only even values into saved program counters
// RL15 - exception or maskable interrupt saves pc and status to irq pair
// RL16 - saved pc is address of the following instruction
// RL17 - non-maskable interrupt saves pc and status to nmi pair
// RL18 - saved pc bits 31-26, status bits 31-12 and 10-8 read zero
// RL19 - nested handlers save the single pair themselves
// RL20 - every exception or interrupt loads the cause register
// RL21 - loaded status takes effect on completion; reserved bits read zero
// RL22 - setting disable flag blocks maskable interrupts during the load; here irq_mask_o rises only at the edge that ends the load
// RL23 - status bit 5 disables interrupts, 6 exception, 7 nmi active
// RL24 - debug interface bit 0 shows debug mode, not software writable
// RL25 - two read ports and one write port per cycle
// RL26 - refused loads leave the target register unchanged
module cpu_register_set
	import cpu_regs_pkg::*;
(
	// clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     rst_n_i,
	// general register ports
	input  wire logic [4:0]               rd_a_idx_i,
	input  wire logic [4:0]               rd_b_idx_i,
	input  wire logic                     wr_en_i,
	input  wire logic [4:0]               wr_idx_i,
	input  wire logic [31:0]              wr_data_i,
	output logic [31:0]                   rd_a_data_o,
	output logic [31:0]                   rd_b_data_o,
	// program counter control
	input  wire logic                     pc_load_i,
	input  wire logic [31:0]              pc_load_val_i,
	input  wire logic                     pc_add_i,
	input  wire logic [31:0]              pc_add_val_i,
	input  wire logic                     ret_i,
	input  wire logic [1:0]               ret_src_i,
	output logic [31:0]                   pc_o,
	// system register load and store
	input  wire cpu_regs_pkg::sysreg_req_s ld_i,
	input  wire logic                     st_en_i,
	input  wire logic [4:0]               st_num_i,
	output logic [31:0]                   st_data_o,
	output logic                          st_valid_o,
	// exception sequencing
	input  wire cpu_regs_pkg::event_s     ev_i,
	output logic [31:0]                   status_o,
	output logic                          irq_mask_o,
	output logic                          debug_mode_o
);
	import cpu_regs_pkg::*;

	state_s st_ff;
	state_s nxt_st;

	// reserved bits in each saved or stored value are forced to zero
	function automatic logic [31:0] wr_mask(input logic [4:0] n);
		unique case (n)
			SR_IRQ_PC, SR_NMI_PC, SR_TC_PC, SR_TRAP_PC: wr_mask = PCSAVE_MASK; // RL18
			SR_IRQ_ST, SR_NMI_ST, SR_TC_ST, SR_TRAP_ST, SR_STATUS: wr_mask = STAT_MASK; // RL18 RL21
			SR_TC_BASE: wr_mask = TBASE_MASK;
			SR_DBG_IF: wr_mask = DIR_WR_MASK; // RL24
			default: wr_mask = ALL_ONES;
		endcase
	endfunction

	function automatic logic dbg_only_rd(input logic [4:0] n);
		dbg_only_rd = (n == SR_TRAP_PC) || (n == SR_TRAP_ST) || (n == SR_BRK_CTL) ||
			(n >= SR_BRK_FIRST && n <= SR_BRK_LAST); // RL11
	endfunction

	function automatic logic dbg_only_wr(input logic [4:0] n);
		dbg_only_wr = (n == SR_DBG_IF) || (n == SR_BRK_CTL) ||
			(n >= SR_BRK_FIRST && n <= SR_BRK_LAST); // RL11
	endfunction

	function automatic logic [2:0] brk_slot(input logic [4:0] n);
		brk_slot = (n == SR_BRK_CTL) ? 3'h0 : 3'(n - SR_BRK_FIRST + 5'h01);
	endfunction

	function automatic logic is_brk(input logic [4:0] n);
		is_brk = (n == SR_BRK_CTL) || (n >= SR_BRK_FIRST && n <= SR_BRK_LAST); // RL12
	endfunction

	// one read port; a same-cycle write is forwarded so no hazard is seen
	function automatic logic [31:0] gpr_read(input state_s s, input logic [4:0] idx,
		input logic we, input logic [4:0] widx, input logic [31:0] wd);
		if (idx == 5'h00)
			gpr_read = ZERO32; // RL3
		else if (we && widx == idx)
			gpr_read = wd;
		else
			gpr_read = s.gpr[idx];
	endfunction

	logic        dm;
	logic        cs;
	logic [31:0] sr_val;

	assign dm = st_ff.debug_interface[DM_BIT];
	assign cs = st_ff.debug_interface[CS_BIT];

	always_comb begin
		unique case (st_num_i) // RL8
			SR_IRQ_PC: sr_val = st_ff.irq_saved_pc;
			SR_IRQ_ST: sr_val = st_ff.irq_saved_status;
			SR_NMI_PC: sr_val = st_ff.nmi_saved_pc;
			SR_NMI_ST: sr_val = st_ff.nmi_saved_status;
			SR_CAUSE: sr_val = st_ff.exception_cause; // RL9
			SR_STATUS: sr_val = st_ff.status_word;
			SR_TC_PC: sr_val = st_ff.table_call_saved_pc;
			SR_TC_ST: sr_val = st_ff.table_call_saved_status;
			SR_TRAP_PC: sr_val = st_ff.trap_saved_pc;
			SR_TRAP_ST: sr_val = st_ff.trap_saved_status;
			SR_TC_BASE: sr_val = st_ff.table_call_base;
			SR_DBG_IF: sr_val = st_ff.debug_interface;
			SR_PROG_ID: sr_val = st_ff.program_id;
			default: sr_val = is_brk(st_num_i) ? st_ff.brk[brk_slot(st_num_i)][cs] : ZERO32; // RL12
		endcase
	end

	always_comb begin
		nxt_st = st_ff;

		// two reads and one write every cycle
		nxt_st.rd_a = gpr_read(st_ff, rd_a_idx_i, wr_en_i, wr_idx_i, wr_data_i); // RL25
		nxt_st.rd_b = gpr_read(st_ff, rd_b_idx_i, wr_en_i, wr_idx_i, wr_data_i); // RL25
		if (wr_en_i && wr_idx_i != 5'h00)
			nxt_st.gpr[wr_idx_i] = wr_data_i; // RL2 RL3

		// restricted reads outside debug mode return zero
		nxt_st.st_valid = st_en_i;
		nxt_st.st_data = (dbg_only_rd(st_num_i) && !dm) ? ZERO32 : sr_val; // RL7 RL11

		// program counter: return beats load beats add
		if (ret_i) begin
			unique case (ret_src_i)
				RET_NMI: nxt_st.pc = st_ff.nmi_saved_pc & PC_MASK; // RL13
				RET_TC: nxt_st.pc = st_ff.table_call_saved_pc & PC_MASK; // RL13
				default: nxt_st.pc = st_ff.irq_saved_pc & PC_MASK; // RL13
			endcase
			unique case (ret_src_i)
				RET_NMI: nxt_st.status_word = st_ff.nmi_saved_status;
				RET_TC: nxt_st.status_word = st_ff.table_call_saved_status;
				default: nxt_st.status_word = st_ff.irq_saved_status;
			endcase
		end else if (pc_load_i)
			nxt_st.pc = pc_load_val_i & PC_MASK; // RL4 RL6
		else if (pc_add_i)
			nxt_st.pc = (st_ff.pc + pc_add_val_i) & PC_MASK; // RL5

		// system register load; refused targets keep their contents
		if (ld_i.en && !(dbg_only_wr(ld_i.num) && !dm)) begin // RL26
			unique case (ld_i.num)
				SR_IRQ_PC: nxt_st.irq_saved_pc = ld_i.data & wr_mask(ld_i.num);
				SR_IRQ_ST: nxt_st.irq_saved_status = ld_i.data & wr_mask(ld_i.num);
				SR_NMI_PC: nxt_st.nmi_saved_pc = ld_i.data & wr_mask(ld_i.num);
				SR_NMI_ST: nxt_st.nmi_saved_status = ld_i.data & wr_mask(ld_i.num);
				SR_STATUS: nxt_st.status_word = ld_i.data & wr_mask(ld_i.num); // RL21
				SR_TC_PC: nxt_st.table_call_saved_pc = ld_i.data & wr_mask(ld_i.num);
				SR_TC_ST: nxt_st.table_call_saved_status = ld_i.data & wr_mask(ld_i.num);
				SR_TRAP_PC: nxt_st.trap_saved_pc = ld_i.data & wr_mask(ld_i.num);
				SR_TRAP_ST: nxt_st.trap_saved_status = ld_i.data & wr_mask(ld_i.num);
				SR_TC_BASE: nxt_st.table_call_base = ld_i.data & wr_mask(ld_i.num);
				SR_DBG_IF: nxt_st.debug_interface = (st_ff.debug_interface & ~DIR_WR_MASK) |
					(ld_i.data & DIR_WR_MASK); // RL24
				SR_PROG_ID: nxt_st.program_id = ld_i.data;
				default: begin
					// cause register and reserved numbers fall here untouched
					if (is_brk(ld_i.num))
						nxt_st.brk[brk_slot(ld_i.num)][cs] = ld_i.data; // RL12
				end
			endcase
		end

		// hardware events win over a load in the same cycle
		if (ev_i.nmi) begin
			nxt_st.nmi_saved_pc = ev_i.ret_pc & PCSAVE_MASK; // RL16 RL17
			nxt_st.nmi_saved_status = st_ff.status_word & STAT_MASK; // RL17
			nxt_st.exception_cause = ev_i.cause; // RL20
			nxt_st.status_word[NP_BIT] = 1'b1; // RL23
			nxt_st.status_word[ID_BIT] = 1'b1;
		end else if (ev_i.irq) begin
			nxt_st.irq_saved_pc = ev_i.ret_pc & PCSAVE_MASK; // RL15 RL16
			nxt_st.irq_saved_status = st_ff.status_word & STAT_MASK; // RL15
			nxt_st.exception_cause = ev_i.cause; // RL20
			nxt_st.status_word[EP_BIT] = 1'b1; // RL23
			nxt_st.status_word[ID_BIT] = 1'b1;
		end
		if (ev_i.tcall) begin
			nxt_st.table_call_saved_pc = ev_i.ret_pc & PCSAVE_MASK;
			nxt_st.table_call_saved_status = st_ff.status_word & STAT_MASK;
		end
		if (ev_i.dbg_enter) begin
			nxt_st.trap_saved_pc = ev_i.ret_pc & PCSAVE_MASK;
			nxt_st.trap_saved_status = st_ff.status_word & STAT_MASK;
			nxt_st.debug_interface[DM_BIT] = 1'b1; // RL24
		end else if (ev_i.dbg_exit)
			nxt_st.debug_interface[DM_BIT] = 1'b0; // RL24
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin // RL1
		if (!rst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rd_a_data_o = st_ff.rd_a;
	assign rd_b_data_o = st_ff.rd_b;
	assign pc_o = st_ff.pc;
	assign st_data_o = st_ff.st_data;
	assign st_valid_o = st_ff.st_valid;
	assign status_o = st_ff.status_word;
	// the disable flag is a flop, so a load setting it blocks from its own edge
	assign irq_mask_o = st_ff.status_word[ID_BIT]; // RL22
	assign debug_mode_o = st_ff.debug_interface[DM_BIT];

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_zero_reg;
		rd_a_idx_i == 5'h00 |=> rd_a_data_o == ZERO32;
	endproperty
	a_zero_reg: assert property (p_zero_reg) else $error("register 0 read nonzero"); // RL3

	sequence s_wr_then_rd;
		wr_en_i && wr_idx_i != 5'h00 ##1 !wr_en_i && rd_b_idx_i == $past(wr_idx_i);
	endsequence
	property p_wr_rd;
		logic [31:0] d;
		(wr_en_i && wr_idx_i != 5'h00, d = wr_data_i) ##1
			(!wr_en_i && rd_b_idx_i == $past(wr_idx_i)) |=> rd_b_data_o == d;
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("written value not read back"); // RL2

	property p_pc_shape;
		pc_o[31:PC_BITS] == 6'h00 && pc_o[0] == 1'b0;
	endproperty
	a_pc_shape: assert property (p_pc_shape) else $error("pc reserved bits set"); // RL4

	property p_pc_add;
		pc_add_i && !pc_load_i && !ret_i |=> pc_o == (($past(pc_o) + $past(pc_add_val_i)) & PC_MASK);
	endproperty
	a_pc_add: assert property (p_pc_add) else $error("pc add wrong"); // RL5

	property p_cause_ro;
		ld_i.en && ld_i.num == SR_CAUSE && !ev_i.irq && !ev_i.nmi |=> $stable(st_ff.exception_cause);
	endproperty
	a_cause_ro: assert property (p_cause_ro) else $error("cause register was loaded"); // RL9

	property p_irq_save;
		ev_i.irq && !ev_i.nmi |=> st_ff.irq_saved_pc == ($past(ev_i.ret_pc) & PCSAVE_MASK) &&
			st_ff.irq_saved_status == ($past(status_o) & STAT_MASK) && irq_mask_o;
	endproperty
	a_irq_save: assert property (p_irq_save) else $error("irq save wrong"); // RL15

	property p_nmi_save;
		ev_i.nmi |=> st_ff.nmi_saved_pc == ($past(ev_i.ret_pc) & PCSAVE_MASK) && status_o[NP_BIT];
	endproperty
	a_nmi_save: assert property (p_nmi_save) else $error("nmi save wrong"); // RL17

	property p_cause_load;
		ev_i.irq || ev_i.nmi |=> st_ff.exception_cause == $past(ev_i.cause);
	endproperty
	a_cause_load: assert property (p_cause_load) else $error("cause not loaded"); // RL20

	sequence s_status_ld;
		ld_i.en && ld_i.num == SR_STATUS && !ev_i.irq && !ev_i.nmi && !ret_i;
	endsequence
	property p_status_ld;
		s_status_ld |=> status_o == ($past(ld_i.data) & STAT_MASK) && irq_mask_o == $past(ld_i.data[ID_BIT]);
	endproperty
	a_status_ld: assert property (p_status_ld) else $error("status load wrong"); // RL21

	property p_ret_even;
		ret_i ##1 1'b1 |-> pc_o[0] == 1'b0;
	endproperty
	a_ret_even: assert property (p_ret_even) else $error("return pc odd"); // RL13

	property p_dbg_rd;
		st_en_i && dbg_only_rd(st_num_i) && !debug_mode_o |=> st_valid_o && st_data_o == ZERO32;
	endproperty
	a_dbg_rd: assert property (p_dbg_rd) else $error("restricted read leaked"); // RL11

	property p_dbg_wr;
		ld_i.en && ld_i.num == SR_BRK_CTL && !debug_mode_o |=> $stable(st_ff.brk);
	endproperty
	a_dbg_wr: assert property (p_dbg_wr) else $error("restricted write took effect"); // RL26
endmodule

/* File: sim/pipe_model.sv */
`timescale 1ns/10ps
module pipe_model
	import cpu_regs_pkg::*;
(
	// clock
	input  wire logic                 mclk_i,
	// requests toward the register set
	output cpu_regs_pkg::sysreg_req_s ld_o,
	output cpu_regs_pkg::event_s      ev_o
);
	initial begin
		ld_o = '0;
		ev_o = '0;
	end
	// one-cycle load; released lines show the inverse so stale data is never mistaken for live
	task automatic load(input logic [4:0] num, input logic [31:0] data, input bit odd);
		// reserved numbers are never loaded by well-behaved software
		if (num inside {[5'h06:5'h0f], [5'h1c:5'h1f]})
			return;
		@(negedge mclk_i);
		ld_o.en = 1'b1;
		ld_o.num = num;
		ld_o.data = data;
		if (!odd && (num == SR_IRQ_PC || num == SR_NMI_PC || num == SR_TC_PC))
			ld_o.data[0] = 1'b0;
		@(negedge mclk_i);
		ld_o = '{en: 1'b0, num: ~num, data: ~data};
	endtask
	// kind 0 irq, 1 nmi, 2 debug entry, 3 debug exit, 4 table call
	task automatic raise(input int kind, input logic [31:0] cause, input logic [31:0] ret_pc);
		@(negedge mclk_i);
		ev_o.irq = (kind == 0);
		ev_o.nmi = (kind == 1);
		ev_o.dbg_enter = (kind == 2);
		ev_o.dbg_exit = (kind == 3);
		ev_o.tcall = (kind == 4);
		ev_o.cause = cause;
		ev_o.ret_pc = ret_pc;
		@(negedge mclk_i);
		ev_o = '{cause: ~cause, ret_pc: ~ret_pc, default: 1'b0};
	endtask
endmodule

/* File: sim/test_cpu_register_set.sv */
`timescale 1ns/10ps
module test_cpu_register_set;
	import cpu_regs_pkg::*;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [4:0]  rd_a_idx_i = '0, rd_b_idx_i = '0, wr_idx_i = '0, st_num_i = '0;
	logic        wr_en_i = 1'b0, pc_load_i = 1'b0, pc_add_i = 1'b0, ret_i = 1'b0, st_en_i = 1'b0;
	logic [31:0] wr_data_i = '0, pc_load_val_i = '0, pc_add_val_i = '0;
	logic [1:0]  ret_src_i = '0;
	logic [31:0] rd_a_data_o, rd_b_data_o, pc_o, st_data_o, status_o;
	logic        st_valid_o, irq_mask_o, debug_mode_o;
	sysreg_req_s ld_i;
	event_s      ev_i;
	int          n_mismatch = 0;
	int          check_count = 0;
	logic [31:0] gpr_exp [32];
	logic [31:0] v, c, r, st, pcx;

	always #5 mclk_i = ~mclk_i;

	pipe_model i_pipe_model (.mclk_i, .ld_o(ld_i), .ev_o(ev_i));
	cpu_register_set i_cpu_register_set (.mclk_i, .rst_n_i, .rd_a_idx_i, .rd_b_idx_i, .wr_en_i, .wr_idx_i,
		.wr_data_i, .rd_a_data_o, .rd_b_data_o, .pc_load_i, .pc_load_val_i, .pc_add_i, .pc_add_val_i, .ret_i,
		.ret_src_i, .pc_o, .ld_i, .st_en_i, .st_num_i, .st_data_o, .st_valid_o, .ev_i, .status_o, .irq_mask_o,
		.debug_mode_o);

	function automatic logic [31:0] exp_pc(input logic [31:0] x);
		return x & PC_MASK;
	endfunction
	function automatic logic [31:0] exp_stat(input logic [31:0] x);
		return x & STAT_MASK;
	endfunction

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic store(input logic [4:0] num, input logic [31:0] exp);
		@(negedge mclk_i);
		st_en_i = 1'b1;
		st_num_i = num;
		@(negedge mclk_i);
		st_en_i = 1'b0;
		chk_bit(st_valid_o, 1'b1);
		chk_word(st_data_o, exp);
	endtask
	// op 0 load, 1 add, 2 return from the pair selected by src
	task automatic pc_op(input int op, input logic [31:0] val, input logic [1:0] src, input logic [31:0] exp);
		@(negedge mclk_i);
		pc_load_i = (op == 0);
		pc_add_i = (op == 1);
		ret_i = (op == 2);
		pc_load_val_i = val;
		pc_add_val_i = val;
		ret_src_i = src;
		@(negedge mclk_i);
		{pc_load_i, pc_add_i, ret_i} = '0;
		chk_word(pc_o, exp);
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#900000;
		n_mismatch++;
		final_report();
	end

	initial begin
		void'($urandom(32'hec82));
		repeat (16) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1'b1;
		chk_word(pc_o, ZERO32);
		chk_word(status_o, ZERO32);
		chk_bit(debug_mode_o, 1'b0);
		// write and read the same register in one cycle exercises forwarding on port a
		foreach (gpr_exp[i]) gpr_exp[i] = ZERO32;
		for (int i = 0; i < 32; i++) begin
			v = $urandom;
			@(negedge mclk_i);
			{wr_en_i, wr_idx_i, wr_data_i, rd_a_idx_i, rd_b_idx_i} = {1'b1, 5'(i), v, 5'(i), 5'(i - 1)};
			gpr_exp[i] = (i == 0) ? ZERO32 : v;
			@(negedge mclk_i);
			wr_en_i = 1'b0;
			chk_word(rd_a_data_o, gpr_exp[i]);
			chk_word(rd_b_data_o, gpr_exp[(i + 31) % 32]);
		end
		v = $urandom;
		pc_op(0, v, 2'h0, exp_pc(v));
		pc_op(0, 32'h03ff_fffe, 2'h0, 32'h03ff_fffe);
		pc_op(1, 32'h0000_0004, 2'h0, 32'h0000_0002);
		v = $urandom;
		pc_op(1, v, 2'h0, exp_pc(32'h0000_0002 + v));
		v = $urandom | 32'h0000_0020;
		i_pipe_model.load(SR_STATUS, v, 1'b0);
		chk_word(status_o, exp_stat(v));
		chk_bit(irq_mask_o, 1'b1);
		store(SR_STATUS, exp_stat(v));
		i_pipe_model.load(SR_CAUSE, $urandom, 1'b0);
		store(SR_CAUSE, ZERO32);
		st = status_o;
		c = $urandom;
		r = $urandom;
		i_pipe_model.raise(0, c, r);
		chk_word(status_o, st | 32'h0000_0060);
		store(SR_IRQ_PC, r & PCSAVE_MASK);
		store(SR_IRQ_ST, st);
		store(SR_CAUSE, c);
		st = status_o;
		c = $urandom;
		r = $urandom;
		i_pipe_model.raise(1, c, r);
		chk_word(status_o, st | 32'h0000_00a0);
		store(SR_NMI_PC, r & PCSAVE_MASK);
		store(SR_NMI_ST, st);
		store(SR_CAUSE, c);
		pc_op(2, ZERO32, RET_NMI, exp_pc(r));
		chk_word(status_o, st);
		pcx = $urandom | 32'h0000_0001;
		v = $urandom;
		i_pipe_model.load(SR_IRQ_PC, pcx, 1'b1);
		i_pipe_model.load(SR_IRQ_ST, v, 1'b0);
		store(SR_IRQ_PC, pcx & PCSAVE_MASK);
		store(SR_IRQ_ST, exp_stat(v));
		pc_op(2, ZERO32, RET_IRQ, exp_pc(pcx));
		chk_word(status_o, exp_stat(v));
		r = $urandom;
		i_pipe_model.raise(4, ZERO32, r);
		store(SR_TC_PC, r & PCSAVE_MASK);
		pc_op(2, ZERO32, RET_TC, exp_pc(r));
		for (int n = 6; n < 32; n++)
			if (n < 16 || n > 27)
				store(5'(n), ZERO32);
		v = $urandom;
		i_pipe_model.load(SR_TRAP_PC, v, 1'b0);
		store(SR_TRAP_PC, ZERO32);
		i_pipe_model.load(SR_BRK_CTL, $urandom, 1'b0);
		// debug entry overwrites the trap pair with its own return address
		i_pipe_model.raise(2, ZERO32, v);
		chk_bit(debug_mode_o, 1'b1);
		store(SR_TRAP_PC, v & PCSAVE_MASK);
		store(SR_BRK_CTL, ZERO32);
		c = $urandom;
		r = $urandom;
		i_pipe_model.load(SR_DBG_IF, ZERO32, 1'b0);
		i_pipe_model.load(SR_BRK_CTL, c, 1'b0);
		i_pipe_model.load(SR_DBG_IF, 32'h0000_1000, 1'b0);
		i_pipe_model.load(SR_BRK_CTL, r, 1'b0);
		store(SR_BRK_CTL, r);
		i_pipe_model.load(SR_DBG_IF, ZERO32, 1'b0);
		store(SR_BRK_CTL, c);
		chk_bit(debug_mode_o, 1'b1);
		i_pipe_model.raise(3, ZERO32, ZERO32);
		chk_bit(debug_mode_o, 1'b0);
		store(SR_BRK_CTL, ZERO32);
		final_report();
	end
endmodule
